//--- hdl/vcc_pkg.sv
// Package of constants and types for the voltage comparator control block.
package vcc_pkg;
   // ==========================================================
   // Geometry and special-function register decode
   // ==========================================================
   localparam int        NUM_CMP        = 3;
   localparam logic [7:0] CTRL_ADDR     = 8'h88;
   localparam logic [7:0] MODE_ADDR     = 8'h89;
   localparam logic [7:0] PAGE_BASE     = 8'h01;
   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int CTRL_ON_BIT   = 7;
   localparam int CTRL_OUT_BIT  = 6;
   localparam int CTRL_RISE_BIT = 5;
   localparam int CTRL_FALL_BIT = 4;
   localparam int CTRL_HYP_LSB  = 2;
   localparam int CTRL_HYN_LSB  = 0;
   localparam int MODE_RIE_BIT  = 5;
   localparam int MODE_FIE_BIT  = 4;
   localparam int MODE_MD_LSB   = 0;
   // ==========================================================
   // Reset values and writable mask
   // ==========================================================
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h02;
   localparam logic [7:0] MODE_WMASK = 8'h33;
   // ==========================================================
   // Types
   // ==========================================================
   typedef struct packed {
      logic       cmpOn;
      logic [1:0] posHysteresisSel;
      logic [1:0] negHysteresisSel;
      logic [1:0] responseModeSel;
   } vcc_analog_cfg_t;

   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] page;
      logic [7:0] wdata;
   } vcc_sfr_req_t;
endpackage : vcc_pkg

//--- hdl/vcc_sync.sv
// Three-stage synchroniser with agreement filter for the analog result.
`timescale 1ns/100ps
`default_nettype none
module vcc_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Data
   input  wire logic asyncIn,
   output var  logic syncOut
);
   logic stage1_reg;
   logic stage2_reg;
   logic stage3_reg;
   logic syncOut_next;

   // A change counts only once the second and third stages agree.
   assign syncOut_next = (stage2_reg == stage3_reg) ? stage3_reg : syncOut;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
         stage3_reg <= 1'b0;
         syncOut    <= 1'b0;
      end else begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         syncOut    <= syncOut_next;
      end
   end
endmodule : vcc_sync
`default_nettype wire

//--- hdl/vcc_channel.sv
// One comparator channel: control and mode registers, edge flags, request.
`timescale 1ns/100ps
`default_nettype none
module vcc_channel (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // Register access, already decoded for this channel
   input  wire logic                 ctrlWr,
   input  wire logic                 modeWr,
   input  wire logic [7:0]           wdata,
   // Comparator result, already synchronised to clk
   input  wire logic                 cmpSync,
   // Results
   output var  logic [7:0]           ctrlRd,
   output var  logic [7:0]           modeRd,
   output var  logic                 resultState,
   output var  logic                 edgeIrq,
   output var  vcc_pkg::vcc_analog_cfg_t cfg
);
   logic       lastState_reg;
   logic       cmpOn_reg;
   logic       riseFlag_reg;
   logic       fallFlag_reg;
   logic [1:0] posHys_reg;
   logic [1:0] negHys_reg;
   logic [7:0] mode_reg;
   logic       riseEvt;
   logic       fallEvt;
   logic       riseFlag_next;
   logic       fallFlag_next;

   // A disabled comparator reads and drives low.
   assign resultState = cmpOn_reg & cmpSync;
   assign riseEvt     = resultState & ~lastState_reg;
   assign fallEvt     = ~resultState & lastState_reg;

   // Hardware set wins over a software clear in the same cycle.
   assign riseFlag_next = riseEvt |
      (ctrlWr ? wdata[vcc_pkg::CTRL_RISE_BIT] : riseFlag_reg);
   assign fallFlag_next = fallEvt |
      (ctrlWr ? wdata[vcc_pkg::CTRL_FALL_BIT] : fallFlag_reg);

   assign ctrlRd = {cmpOn_reg, resultState, riseFlag_reg, fallFlag_reg,
                    posHys_reg, negHys_reg};
   assign modeRd = mode_reg;
   assign edgeIrq = (riseFlag_reg & mode_reg[vcc_pkg::MODE_RIE_BIT]) |
                    (fallFlag_reg & mode_reg[vcc_pkg::MODE_FIE_BIT]);
   assign cfg = '{cmpOn: cmpOn_reg, posHysteresisSel: posHys_reg,
                  negHysteresisSel: negHys_reg,
                  responseModeSel: mode_reg[vcc_pkg::MODE_MD_LSB +: 2]};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lastState_reg <= 1'b0;
         cmpOn_reg     <= vcc_pkg::CTRL_RESET[vcc_pkg::CTRL_ON_BIT];
         riseFlag_reg  <= vcc_pkg::CTRL_RESET[vcc_pkg::CTRL_RISE_BIT];
         fallFlag_reg  <= vcc_pkg::CTRL_RESET[vcc_pkg::CTRL_FALL_BIT];
         posHys_reg    <= vcc_pkg::CTRL_RESET[vcc_pkg::CTRL_HYP_LSB +: 2];
         negHys_reg    <= vcc_pkg::CTRL_RESET[vcc_pkg::CTRL_HYN_LSB +: 2];
         mode_reg      <= vcc_pkg::MODE_RESET;
      end else begin
         lastState_reg <= resultState;
         riseFlag_reg  <= riseFlag_next;
         fallFlag_reg  <= fallFlag_next;
         if (ctrlWr) begin
            cmpOn_reg  <= wdata[vcc_pkg::CTRL_ON_BIT];
            posHys_reg <= wdata[vcc_pkg::CTRL_HYP_LSB +: 2];
            negHys_reg <= wdata[vcc_pkg::CTRL_HYN_LSB +: 2];
         end
         if (modeWr) begin
            mode_reg <= wdata & vcc_pkg::MODE_WMASK;
         end
      end
   end
endmodule : vcc_channel
`default_nettype wire

//--- hdl/vcc_top.sv
// Top of the three-channel voltage comparator control block.
`timescale 1ns/100ps
`default_nettype none
module vcc_top (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // Special-function register access
   input  wire vcc_pkg::vcc_sfr_req_t    sfrReq,
   output var  logic [7:0]               sfrRdata,
   output var  logic                     sfrHit,
   // Extended interrupt enables from the core, one per comparator
   input  wire logic [2:0]               extIrqEnable,
   // Analog comparator results, asynchronous
   input  wire logic [2:0]               cmpRaw,
   // Settings toward the analog comparators
   output var  vcc_pkg::vcc_analog_cfg_t cmpCfg [3],
   // Result fan-out
   output var  logic [2:0]               pinOut,
   output var  logic [2:0]               resetSrc,
   output var  logic [2:0]               cmpIrq
);
   wire logic [2:0]          pageSel;
   wire logic [2:0]          ctrlWr;
   wire logic [2:0]          modeWr;
   wire logic [2:0]          cmpSync;
   logic [7:0]               ctrlRd [3];
   logic [7:0]               modeRd [3];
   wire logic [2:0]          resultState;
   wire logic [2:0]          edgeIrq;
   vcc_pkg::vcc_analog_cfg_t cfgNext [3];
   logic                     isCtrl;
   logic                     isMode;
   logic [7:0]               rdNext;
   logic                     hitNext;

   // ==========================================================
   // Address decode
   // ==========================================================
   assign isCtrl = (sfrReq.addr == vcc_pkg::CTRL_ADDR);
   assign isMode = (sfrReq.addr == vcc_pkg::MODE_ADDR);

   // ==========================================================
   // Channels
   // ==========================================================
   for (genvar i = 0; i < vcc_pkg::NUM_CMP; i++) begin : g_cmp
      assign pageSel[i] = (sfrReq.page == vcc_pkg::PAGE_BASE + 8'(i));
      assign ctrlWr[i]  = sfrReq.wrEn & isCtrl & pageSel[i];
      assign modeWr[i]  = sfrReq.wrEn & isMode & pageSel[i];

      // The raw result is asynchronous, so it is filtered before any edge logic sees it.
      vcc_sync u_sync (
         .clk     (clk),
         .rst_n   (rst_n),
         .asyncIn (cmpRaw[i]),
         .syncOut (cmpSync[i])
      );

      vcc_channel u_chan (
         .clk         (clk),
         .rst_n       (rst_n),
         .ctrlWr      (ctrlWr[i]),
         .modeWr      (modeWr[i]),
         .wdata       (sfrReq.wdata),
         .cmpSync     (cmpSync[i]),
         .ctrlRd      (ctrlRd[i]),
         .modeRd      (modeRd[i]),
         .resultState (resultState[i]),
         .edgeIrq     (edgeIrq[i]),
         .cfg         (cfgNext[i])
      );

      // Outputs are registered, so each lags the internal state by one cycle.
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            pinOut[i]   <= 1'b0;
            resetSrc[i] <= 1'b0;
            cmpIrq[i]   <= 1'b0;
            cmpCfg[i]   <= '{cmpOn: vcc_pkg::CTRL_RESET[vcc_pkg::CTRL_ON_BIT],
                             posHysteresisSel: vcc_pkg::CTRL_RESET[vcc_pkg::CTRL_HYP_LSB +: 2],
                             negHysteresisSel: vcc_pkg::CTRL_RESET[vcc_pkg::CTRL_HYN_LSB +: 2],
                             responseModeSel: vcc_pkg::MODE_RESET[vcc_pkg::MODE_MD_LSB +: 2]};
         end else begin
            pinOut[i]   <= resultState[i];
            resetSrc[i] <= resultState[i];
            cmpIrq[i]   <= edgeIrq[i] & extIrqEnable[i];
            cmpCfg[i]   <= cfgNext[i];
         end
      end
   end

   // ==========================================================
   // Read mux
   // ==========================================================
   always_comb begin
      rdNext  = 8'h00;
      hitNext = 1'b0;
      for (int k = 0; k < vcc_pkg::NUM_CMP; k++) begin
         if (sfrReq.rdEn && pageSel[k] && isCtrl) begin
            rdNext  = ctrlRd[k];
            hitNext = 1'b1;
         end else if (sfrReq.rdEn && pageSel[k] && isMode) begin
            rdNext  = modeRd[k];
            hitNext = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sfrRdata <= 8'h00;
         sfrHit   <= 1'b0;
      end else begin
         sfrRdata <= rdNext;
         sfrHit   <= hitNext;
      end
   end
endmodule : vcc_top
`default_nettype wire

//--- verification/vcc_top_sva.sv
// Concurrent checks on the ports of the comparator control top.
`timescale 1ns/100ps
`default_nettype none
module vcc_top_sva (
   // Clock and reset
   input wire logic                     clk,
   input wire logic                     rst_n,
   // Watched ports
   input wire vcc_pkg::vcc_sfr_req_t    sfrReq,
   input wire logic [7:0]               sfrRdata,
   input wire logic                     sfrHit,
   input wire logic [2:0]               extIrqEnable,
   input wire logic [2:0]               cmpRaw,
   input wire vcc_pkg::vcc_analog_cfg_t cmpCfg [3],
   input wire logic [2:0]               pinOut,
   input wire logic [2:0]               resetSrc,
   input wire logic [2:0]               cmpIrq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic regHit = (sfrReq.addr == vcc_pkg::CTRL_ADDR || sfrReq.addr == vcc_pkg::MODE_ADDR)
                       && sfrReq.page >= 8'h01 && sfrReq.page <= 8'h03;
   wire logic pg1 = sfrReq.wrEn && sfrReq.page == 8'h01;
   wire logic wrCtrl0 = pg1 && sfrReq.addr == vcc_pkg::CTRL_ADDR;
   wire logic wrMode0 = pg1 && sfrReq.addr == vcc_pkg::MODE_ADDR;
   wire logic modeAddr = sfrReq.addr == vcc_pkg::MODE_ADDR;

   a_read_hit:  assert property (sfrReq.rdEn && regHit |=> sfrHit)
      else $error("mapped read gave no hit");
   a_read_miss: assert property (sfrReq.rdEn && !regHit |=> !sfrHit && sfrRdata == 8'h00)
      else $error("unmapped read answered");
   a_hit_cause: assert property (sfrHit |-> $past(sfrReq.rdEn))
      else $error("hit without read");
   a_mode_unused: assert property (sfrHit && $past(modeAddr)
      |-> (sfrRdata & 8'hcc) == 8'h00)
      else $error("unused mode bits not zero");
   // Settings reach cmpCfg one edge after the register itself takes the write.
   a_ctrl_fields: assert property (wrCtrl0 |=> ##1
      cmpCfg[0].cmpOn == $past(sfrReq.wdata[7], 2)
      && cmpCfg[0].posHysteresisSel == $past(sfrReq.wdata[3:2], 2)
      && cmpCfg[0].negHysteresisSel == $past(sfrReq.wdata[1:0], 2))
      else $error("control fields not applied");
   a_mode_field: assert property (wrMode0 |=> ##1
      cmpCfg[0].responseModeSel == $past(sfrReq.wdata[1:0], 2))
      else $error("response mode not applied");
   a_pin_off: assert property ((!cmpCfg[0].cmpOn)[*8] |-> !pinOut[0])
      else $error("disabled comparator drives pin");
   a_reset_src: assert property (resetSrc == pinOut)
      else $error("reset source differs from pin");
   a_irq_ext: assert property (cmpIrq[0] |-> $past(extIrqEnable[0]))
      else $error("request without extended enable");
endmodule : vcc_top_sva
bind vcc_top vcc_top_sva u_sva (.clk(clk), .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
   .sfrHit(sfrHit), .extIrqEnable(extIrqEnable), .cmpRaw(cmpRaw), .cmpCfg(cmpCfg),
   .pinOut(pinOut), .resetSrc(resetSrc), .cmpIrq(cmpIrq));
`default_nettype wire

//--- verification/vcc_core_model.sv
// Software side of the core: register accesses and extended interrupt enables.
`timescale 1ns/100ps
`default_nettype none
module vcc_core_model #(
   parameter int PWRUP_CYC = 1000
) (
   // Clock
   input  wire logic                  clk,
   // Register access and enables
   output var  vcc_pkg::vcc_sfr_req_t sfrReq,
   output var  logic [2:0]            extIrqEnable
);
   initial begin
      sfrReq = '0;
      extIrqEnable = 3'h0;
   end
   // Idle lines show inverted data so nothing relies on a stale value.
   task automatic access(input logic wr, input logic [7:0] a, p, d);
      @(negedge clk);
      sfrReq = '{wr, !wr, a, p, d};
      @(negedge clk);
      sfrReq = '{1'b0, 1'b0, ~a, ~p, ~d};
   endtask : access
   task automatic powerUp();
      repeat (PWRUP_CYC) @(negedge clk);
   endtask : powerUp
   task automatic setExt(input logic [2:0] v);
      @(negedge clk);
      extIrqEnable = v;
   endtask : setExt
endmodule : vcc_core_model
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the comparator control top.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin errCount++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
   logic                     clk, rst_n, sfrHit;
   logic [2:0]               cmpRaw, extIrqEnable, pinOut, cmpIrq;
   logic [7:0]               sfrRdata, h, expV;
   vcc_pkg::vcc_sfr_req_t    sfrReq;
   vcc_pkg::vcc_analog_cfg_t cmpCfg [3];
   logic [7:0]               expQ [$];
   int                       errCount = 0;
   int                       nTests = 0;
   vcc_core_model u_core (.clk(clk), .sfrReq(sfrReq), .extIrqEnable(extIrqEnable));
   vcc_top u_dut (.clk(clk), .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdata(sfrRdata), .sfrHit(sfrHit),
      .extIrqEnable(extIrqEnable), .cmpRaw(cmpRaw), .cmpCfg(cmpCfg), .pinOut(pinOut),
      .resetSrc(), .cmpIrq(cmpIrq));
   task automatic wr(input logic [7:0] a, p, d);
      u_core.access(1'b1, a, p, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, p, e);
      expQ.push_back(e);
      u_core.access(1'b0, a, p, 8'h00);
   endtask : rd
   task automatic printVerdict();
      $display("Comparisons %0d, mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : printVerdict
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(negedge clk) begin
      if (sfrHit === 1'b1) begin
         expV = expQ.pop_front();
         `CHK(sfrRdata, expV)
      end
   end
   initial begin
      #100us;
      errCount++;
      printVerdict();
   end
   initial begin
      void'($urandom(29426));
      rst_n = 1'b0;
      cmpRaw = 3'h0;
      repeat (12) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      cmpRaw[2:1] = 2'($urandom);
      for (int p = 1; p <= 3; p++) begin
         rd(8'h88, p[7:0], 8'h00);
         rd(8'h89, p[7:0], 8'h02);
      end
      for (int m = 0; m < 4; m++) begin
         wr(8'h89, 8'h01, (8'($urandom) & 8'hcc) | 8'h30 | m[7:0]);
         rd(8'h89, 8'h01, 8'h30 | m[7:0]);
      end
      h = 8'($urandom) & 8'h0f;
      wr(8'h88, 8'h01, 8'h80 | h);
      u_core.powerUp();
      rd(8'h88, 8'h01, 8'h80 | h);
      cmpRaw[0] = 1'b1;
      repeat (8) @(negedge clk);
      rd(8'h88, 8'h01, 8'he0 | h);
      `CHK(cmpIrq[0], 1'b0)
      u_core.setExt(3'h1);
      repeat (3) @(negedge clk);
      `CHK(cmpIrq[0], 1'b1)
      `CHK(pinOut[0], 1'b1)
      wr(8'h88, 8'h01, 8'h80 | h);
      repeat (3) @(negedge clk);
      `CHK(cmpIrq[0], 1'b0)
      rd(8'h88, 8'h01, 8'hc0 | h);
      cmpRaw[0] = 1'b0;
      repeat (8) @(negedge clk);
      rd(8'h88, 8'h01, 8'h90 | h);
      `CHK(cmpIrq[0], 1'b1)
      cmpRaw[0] = 1'b1;
      repeat (8) @(negedge clk);
      wr(8'h88, 8'h01, h);
      repeat (10) @(negedge clk);
      rd(8'h88, 8'h01, 8'h10 | h);
      `CHK(pinOut, 3'h0)
      wr(8'h88, 8'h04, 8'hff);
      wr(8'h8a, 8'h03, 8'hff);
      u_core.access(1'b0, 8'h8a, 8'h01, 8'h00);
      rd(8'h88, 8'h02, 8'h00);
      rd(8'h88, 8'h03, 8'h00);
      repeat (3) @(negedge clk);
      printVerdict();
   end
endmodule : tb
`default_nettype wire
